/* File: hw/bit_flag_move_load_exec.sv */
// Execution unit for I/O bit, shift, flag, move and pointer load operations.
`timescale 1ns/1ps

//Function
// - I/O bit set forces the bit to one, keeps flags, takes two cycles.
// - I/O bit clear forces the bit to zero, keeps flags, takes two cycles.
// - Shifts move one place in one cycle and update Z, C, N and V.
// - Rotate left moves carry into bit 0 and bit 7 into carry in one cycle.
// - Rotate right moves carry into bit 7 and bit 0 into carry in one cycle.
// - Bit store copies one source bit into the transfer flag in one cycle.
// - Bit load puts the transfer flag in one bit in a cycle, keeping flags.
// - Each flag set or clear writes one indexed status flag in one cycle.
// - Global interrupt enable sets only the interrupt flag in one cycle.
// - Global interrupt disable clears only the interrupt flag in one cycle.
// - Copy, pair copy and immediate load take one cycle and keep flags.
// - Post-increment load reads at the pointer, then steps it, two cycles.
// - Pre-decrement loads step back first; plain loads keep the pointer.
module bit_flag_move_load_exec #(
    parameter int IO_DEPTH = exec_pkg::NUM_IO
) (
    input  wire logic                clk_in,
    input  wire logic                resetn_in,
    input  wire logic                op_valid_in,
    input  exec_pkg::op_t            op_code_in,
    input  wire logic          [4:0] dst_sel_in,
    input  wire logic          [4:0] src_sel_in,
    input  wire logic          [2:0] bit_sel_in,
    input  wire logic          [7:0] imm_in,
    input  wire logic          [4:0] io_addr_in,
    input  exec_pkg::ptr_sel_t       ptr_sel_in,
    input  exec_pkg::ptr_mode_t      ptr_mode_in,
    input  wire logic          [7:0] mem_data_in,
    input  wire logic          [4:0] peek_sel_in,
    input  wire logic          [4:0] io_peek_sel_in,
    output logic                     busy_out,
    output logic                     done_out,
    output logic               [7:0] status_out,
    output logic              [15:0] mem_addr_out,
    output logic                     mem_read_out,
    output logic               [7:0] peek_data_out,
    output logic               [7:0] io_peek_data_out
);
    import exec_pkg::*;

    typedef enum logic {st_idle, st_second} state_t;

    // ****************************************************************
    // State
    // ****************************************************************
    logic     [7:0] gpr_reg [NUM_GPR];
    logic     [7:0] io_reg  [IO_DEPTH];
    logic     [7:0] status_reg;
    state_t         state_reg;
    op_t            pend_op_reg;
    logic     [4:0] pend_dst_reg;
    logic     [4:0] pend_io_reg;
    logic     [2:0] pend_bit_reg;
    logic           busy_reg;
    logic           done_reg;
    logic    [15:0] mem_addr_reg;
    logic           mem_read_reg;
    logic     [7:0] peek_reg;
    logic     [7:0] io_peek_reg;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic           accept;
    logic           second;
    logic           is_shift;
    logic           is_pair;
    logic           is_ptr;
    logic           ptr_moves;
    logic           two_cycle;
    logic           writes_reg;
    logic     [7:0] src_val;
    logic     [7:0] dst_val;
    logic     [7:0] bit_mask;
    logic     [7:0] pend_mask;
    logic     [7:0] t_mask;
    logic     [7:0] i_mask;
    logic     [7:0] bld_val;
    logic     [4:0] pair_dst_lo;
    logic     [4:0] pair_src_lo;
    logic     [4:0] ptr_lo_idx;
    logic     [4:0] ptr_hi_idx;
    logic    [15:0] ptr_val;
    logic    [15:0] ptr_inc;
    logic    [15:0] ptr_dec;
    logic    [15:0] ptr_new;
    logic    [15:0] ld_addr;
    logic     [7:0] sh_result;
    logic     [3:0] sh_vnzc;
    logic     [7:0] status_next;
    logic           wr_a_en;
    logic     [4:0] wr_a_idx;
    logic     [7:0] wr_a_data;
    logic           wr_b_en;
    logic     [4:0] wr_b_idx;
    logic     [7:0] wr_b_data;
    logic           io_wr_en;
    logic     [7:0] io_wr_data;

    assign accept   = op_valid_in && (state_reg == st_idle);
    assign second   = (state_reg == st_second);
    assign is_shift = (op_code_in == shift_left_logical_op) ||
                      (op_code_in == shift_right_logical_op) ||
                      (op_code_in == shift_right_arith_op) ||
                      (op_code_in == rotate_left_carry_op) ||
                      (op_code_in == rotate_right_carry_op);
    assign is_pair  = (op_code_in == reg_pair_copy_op);
    assign is_ptr   = (op_code_in == pointer_load_op);
    assign ptr_moves = is_ptr && (ptr_mode_in != ptr_plain);
    assign two_cycle = is_ptr || (op_code_in == io_bit_set_op) ||
                       (op_code_in == io_bit_clear_op);
    assign writes_reg = is_shift || is_pair || ptr_moves ||
                        (op_code_in == nibble_swap_op) ||
                        (op_code_in == transfer_flag_to_bit_op) ||
                        (op_code_in == reg_copy_op) ||
                        (op_code_in == immediate_load_op);

    assign src_val   = gpr_reg[src_sel_in];
    assign dst_val   = gpr_reg[dst_sel_in];
    assign bit_mask  = 8'(8'h01 << bit_sel_in);
    assign pend_mask = 8'(8'h01 << pend_bit_reg);
    assign t_mask    = 8'(8'h01 << FLAG_T);
    assign i_mask    = 8'(8'h01 << FLAG_I);
    assign bld_val   = status_reg[FLAG_T] ? (dst_val | bit_mask) :
                                            (dst_val & ~bit_mask);

    // Pairs always start on an even register.
    assign pair_dst_lo = {dst_sel_in[4:1], 1'b0};
    assign pair_src_lo = {src_sel_in[4:1], 1'b0};

    // ****************************************************************
    // Pointer arithmetic
    // ****************************************************************
    assign ptr_lo_idx = (ptr_sel_in == ptr_x) ? PTR_X_LO : PTR_Y_LO;
    assign ptr_hi_idx = {ptr_lo_idx[4:1], 1'b1};
    assign ptr_val = {gpr_reg[ptr_hi_idx], gpr_reg[ptr_lo_idx]};
    assign ptr_inc = ptr_val + 16'h0001;
    assign ptr_dec = ptr_val - 16'h0001;
    assign ld_addr = (ptr_mode_in == ptr_pre_dec) ? ptr_dec : ptr_val;
    assign ptr_new = (ptr_mode_in == ptr_post_inc) ? ptr_inc :
                     (ptr_mode_in == ptr_pre_dec)  ? ptr_dec : ptr_val;

    shift_unit shifter (
        .op_in      (op_code_in),
        .value_in   (dst_val),
        .carry_in   (status_reg[FLAG_C]),
        .result_out (sh_result),
        .vnzc_out   (sh_vnzc)
    );

    // ****************************************************************
    // Status update
    // ****************************************************************
    assign status_next =
        is_shift ? {status_reg[7:4], sh_vnzc} :
        (op_code_in == indexed_flag_on_op)  ? (status_reg | bit_mask) :
        (op_code_in == indexed_flag_off_op) ? (status_reg & ~bit_mask) :
        (op_code_in == bit_to_transfer_flag_op) ?
            (src_val[bit_sel_in] ? (status_reg | t_mask) :
                                   (status_reg & ~t_mask)) :
        (op_code_in == global_irq_on_op)  ? (status_reg | i_mask) :
        (op_code_in == global_irq_off_op) ? (status_reg & ~i_mask) :
        status_reg;

    // ****************************************************************
    // Register file write ports
    // ****************************************************************
    assign wr_a_en = (accept && writes_reg) ||
                     (second && pend_op_reg == pointer_load_op);
    assign wr_a_idx = second ? pend_dst_reg :
                      is_ptr ? ptr_lo_idx :
                      is_pair ? pair_dst_lo : dst_sel_in;
    assign wr_a_data =
        second ? mem_data_in :
        is_ptr ? ptr_new[7:0] :
        is_pair ? gpr_reg[pair_src_lo] :
        (op_code_in == immediate_load_op) ? imm_in :
        (op_code_in == reg_copy_op) ? src_val :
        (op_code_in == transfer_flag_to_bit_op) ? bld_val :
        sh_result;
    assign wr_b_en   = accept && (is_pair || ptr_moves);
    assign wr_b_idx  = {wr_a_idx[4:1], 1'b1};
    assign wr_b_data = is_ptr ? ptr_new[15:8] :
                       gpr_reg[{src_sel_in[4:1], 1'b1}];

    // I/O bit change lands on the second cycle.
    assign io_wr_en   = second && (pend_op_reg == io_bit_set_op ||
                                   pend_op_reg == io_bit_clear_op);
    assign io_wr_data = (pend_op_reg == io_bit_set_op) ?
                        (io_reg[pend_io_reg] | pend_mask) :
                        (io_reg[pend_io_reg] & ~pend_mask);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < NUM_GPR; i++) begin
                gpr_reg[i] <= GPR_RESET;
            end
            for (int i = 0; i < IO_DEPTH; i++) begin
                io_reg[i] <= IO_RESET;
            end
        end else begin
            if (wr_a_en) begin
                gpr_reg[wr_a_idx] <= wr_a_data;
            end
            if (wr_b_en) begin
                gpr_reg[wr_b_idx] <= wr_b_data;
            end
            if (io_wr_en) begin
                io_reg[pend_io_reg] <= io_wr_data;
            end
        end
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg    <= st_idle;
            status_reg   <= STATUS_RESET;
            pend_op_reg  <= nop_op;
            pend_dst_reg <= 5'h00;
            pend_io_reg  <= 5'h00;
            pend_bit_reg <= 3'h0;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_read_reg <= 1'b0;
        end else begin
            state_reg  <= (accept && two_cycle) ? st_second : st_idle;
            busy_reg   <= accept && two_cycle;
            done_reg   <= (accept && !two_cycle) || second;
            mem_read_reg <= accept && is_ptr;
            if (accept) begin
                status_reg   <= status_next;
                pend_op_reg  <= op_code_in;
                pend_dst_reg <= dst_sel_in;
                pend_io_reg  <= io_addr_in;
                pend_bit_reg <= bit_sel_in;
            end
            if (accept && is_ptr) begin
                mem_addr_reg <= ld_addr;
            end
        end
    end

    // Peek ports are registered so every output comes from a flip-flop;
    // the price is one cycle of lag behind the arrays.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            peek_reg    <= 8'h00;
            io_peek_reg <= 8'h00;
        end else begin
            peek_reg    <= gpr_reg[peek_sel_in];
            io_peek_reg <= io_reg[io_peek_sel_in];
        end
    end

    assign busy_out         = busy_reg;
    assign done_out         = done_reg;
    assign status_out       = status_reg;
    assign mem_addr_out     = mem_addr_reg;
    assign mem_read_out     = mem_read_reg;
    assign peek_data_out    = peek_reg;
    assign io_peek_data_out = io_peek_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    io_set_bit_a: assert property (
        (second && pend_op_reg == io_bit_set_op) |=>
            io_reg[$past(pend_io_reg)][$past(pend_bit_reg)] &&
            $stable(status_reg) && done_out)
        else $error("I/O bit set did not land on the second cycle");

    io_clear_bit_a: assert property (
        (accept && op_code_in == io_bit_clear_op) |=>
            busy_out && !done_out ##1
            done_out && !busy_out &&
            !io_reg[$past(io_addr_in, 2)][$past(bit_sel_in, 2)])
        else $error("I/O bit clear wrong result or timing");

    shift_left_a: assert property (
        (accept && op_code_in == shift_left_logical_op) |=>
            gpr_reg[$past(dst_sel_in)] == {$past(dst_val[6:0]), 1'b0} &&
            status_reg[FLAG_C] == $past(dst_val[7]) && done_out)
        else $error("Left shift result or carry wrong");

    rotate_left_a: assert property (
        (accept && op_code_in == rotate_left_carry_op) |=>
            gpr_reg[$past(dst_sel_in)] ==
                {$past(dst_val[6:0]), $past(status_reg[FLAG_C])} &&
            status_reg[FLAG_C] == $past(dst_val[7]))
        else $error("Rotate left through carry wrong");

    rotate_right_a: assert property (
        (accept && op_code_in == rotate_right_carry_op) |=>
            gpr_reg[$past(dst_sel_in)] ==
                {$past(status_reg[FLAG_C]), $past(dst_val[7:1])} &&
            status_reg[FLAG_C] == $past(dst_val[0]))
        else $error("Rotate right through carry wrong");

    bit_store_a: assert property (
        (accept && op_code_in == bit_to_transfer_flag_op) |=>
            status_reg[FLAG_T] == $past(src_val[bit_sel_in]) &&
            (status_reg & ~t_mask) == $past(status_reg & ~t_mask))
        else $error("Bit store touched the wrong flags");

    irq_enable_a: assert property (
        (accept && op_code_in == global_irq_on_op) |=>
            status_reg == ($past(status_reg) | i_mask))
        else $error("Interrupt enable altered other flags");

    ptr_post_inc_a: assert property (
        (accept && is_ptr && ptr_mode_in == ptr_post_inc) |=>
            mem_read_out && mem_addr_out == $past(ptr_val) &&
            {gpr_reg[$past(ptr_hi_idx)], gpr_reg[$past(ptr_lo_idx)]} ==
                $past(ptr_inc) ##1 done_out)
        else $error("Post-increment load address or pointer wrong");

    ptr_pre_dec_a: assert property (
        (accept && is_ptr && ptr_mode_in == ptr_pre_dec) |=>
            mem_addr_out == $past(ptr_dec) && $stable(status_reg))
        else $error("Pre-decrement load used the wrong address");

    pair_copy_a: assert property (
        (accept && is_pair) |=>
            gpr_reg[{$past(dst_sel_in[4:1]), 1'b1}] ==
                $past(gpr_reg[{src_sel_in[4:1], 1'b1}]) &&
            $stable(status_reg))
        else $error("Register pair copy wrong");

endmodule

/* File: hw/exec_pkg.sv */
// Shared types and constants for the bit, flag, move and load execution unit.
package exec_pkg;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int        NUM_GPR      = 32;
    localparam int        NUM_IO       = 32;
    localparam logic [7:0] GPR_RESET   = 8'h00;
    localparam logic [7:0] IO_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ****************************************************************
    // Status register bit positions
    // ****************************************************************
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ****************************************************************
    // Pointer pairs: low byte index, high byte is the next register
    // ****************************************************************
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;

    // ****************************************************************
    // Cycle counts
    // ****************************************************************
    localparam int ONE_CYCLE_OPS = 1;
    localparam int TWO_CYCLE_OPS = 2;

    typedef enum logic [4:0] {
        nop_op,
        io_bit_set_op,
        io_bit_clear_op,
        shift_left_logical_op,
        shift_right_logical_op,
        shift_right_arith_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        nibble_swap_op,
        indexed_flag_on_op,
        indexed_flag_off_op,
        bit_to_transfer_flag_op,
        transfer_flag_to_bit_op,
        global_irq_on_op,
        global_irq_off_op,
        reg_copy_op,
        reg_pair_copy_op,
        immediate_load_op,
        pointer_load_op
    } op_t;

    typedef enum logic {
        ptr_x,
        ptr_y
    } ptr_sel_t;

    typedef enum logic [1:0] {
        ptr_plain,
        ptr_post_inc,
        ptr_pre_dec
    } ptr_mode_t;

endpackage

/* File: hw/shift_unit.sv */
// Combinational shift, rotate and nibble swap datapath with its flag results.
`timescale 1ns/1ps
module shift_unit (
    input  exec_pkg::op_t op_in,
    input  wire logic [7:0] value_in,
    input  wire logic       carry_in,
    output logic      [7:0] result_out,
    output logic      [3:0] vnzc_out
);
    import exec_pkg::*;

    logic       new_c;
    logic       new_n;
    logic       new_z;

    assign result_out =
        (op_in == shift_left_logical_op)  ? {value_in[6:0], 1'b0} :
        (op_in == shift_right_logical_op) ? {1'b0, value_in[7:1]} :
        (op_in == shift_right_arith_op)   ? {value_in[7], value_in[7:1]} :
        (op_in == rotate_left_carry_op)   ? {value_in[6:0], carry_in} :
        (op_in == rotate_right_carry_op)  ? {carry_in, value_in[7:1]} :
        {value_in[3:0], value_in[7:4]};

    assign new_c = (op_in == shift_left_logical_op ||
                    op_in == rotate_left_carry_op) ? value_in[7] : value_in[0];
    assign new_n = result_out[7];
    assign new_z = (result_out == 8'h00);

    // Overflow follows the usual N xor C convention for shifts.
    assign vnzc_out = {new_n ^ new_c, new_n, new_z, new_c};

endmodule

/* File: verification/bit_flag_move_load_exec_test.sv */
// Self-checking bench for the bit, flag, move and load execution unit.
`timescale 1ns/1ps
module bit_flag_move_load_exec_test;
    import exec_pkg::*;
    logic        clk_in         = 1'b0;
    logic        resetn_in      = 1'b0;
    logic        op_valid_in    = 1'b0;
    op_t         op_code_in     = nop_op;
    logic [4:0]  dst_sel_in     = 5'h00;
    logic [4:0]  src_sel_in     = 5'h00;
    logic [4:0]  io_addr_in     = 5'h00;
    logic [4:0]  peek_sel_in    = 5'h00;
    logic [4:0]  io_peek_sel_in = 5'h00;
    logic [2:0]  bit_sel_in     = 3'h0;
    logic [7:0]  imm_in         = 8'h00;
    logic [7:0]  mem_data_in    = 8'h00;
    ptr_sel_t    ptr_sel_in     = ptr_x;
    ptr_mode_t   ptr_mode_in    = ptr_plain;
    logic        busy_out;
    logic        done_out;
    logic        mem_read_out;
    logic [7:0]  status_out;
    logic [7:0]  peek_data_out;
    logic [7:0]  io_peek_data_out;
    logic [15:0] mem_addr_out;
    int          failures       = 0;
    int          cmp_count      = 0;
    int          cycles         = 0;
    logic [7:0]  st             = 8'h00;
    logic [8:0]  e;
    op_t         sh_ops[6]      = '{shift_left_logical_op,
        shift_right_logical_op, shift_right_arith_op, rotate_left_carry_op,
        rotate_right_carry_op, nibble_swap_op};
    logic [7:0]  vals[3]        = '{8'h81, 8'h00, 8'h40};

    always #25 clk_in = ~clk_in;

    bit_flag_move_load_exec dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .op_valid_in(op_valid_in), .op_code_in(op_code_in),
        .dst_sel_in(dst_sel_in), .src_sel_in(src_sel_in),
        .bit_sel_in(bit_sel_in), .imm_in(imm_in), .io_addr_in(io_addr_in),
        .ptr_sel_in(ptr_sel_in), .ptr_mode_in(ptr_mode_in),
        .mem_data_in(mem_data_in), .peek_sel_in(peek_sel_in),
        .io_peek_sel_in(io_peek_sel_in), .busy_out(busy_out),
        .done_out(done_out), .status_out(status_out),
        .mem_addr_out(mem_addr_out), .mem_read_out(mem_read_out),
        .peek_data_out(peek_data_out), .io_peek_data_out(io_peek_data_out));

    // ****************************************************************
    // Compare, access and closing tasks
    // ****************************************************************
    task automatic chk8(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk16(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits one cycle first so the strobe is never driven twice at once.
    task automatic exec(input op_t op, input logic [4:0] d, s,
                        input logic [2:0] b, input logic [7:0] k, input int n);
        int w;
        @(negedge clk_in);
        op_code_in = op;
        dst_sel_in = d;
        src_sel_in = s;
        bit_sel_in = b;
        imm_in = k;
        op_valid_in = 1'b1;
        @(negedge clk_in);
        op_valid_in = 1'b0;
        chk8("busy", 8'(n == 2), 8'(busy_out));
        chk8("read strobe", 8'(op == pointer_load_op),
             8'(mem_read_out));
        w = 1;
        while (done_out !== 1'b1 && w < 8) begin
            @(negedge clk_in);
            w++;
        end
        chk8("cycles", 8'(n), 8'(w));
        chk8("status", st, status_out);
    endtask

    task automatic peek(input logic [4:0] a, input logic [7:0] exp);
        peek_sel_in = a;
        io_peek_sel_in = a;
        repeat (2) @(negedge clk_in);
        chk8("register", exp, peek_data_out);
    endtask

    task automatic iopeek(input logic [4:0] a, input logic [7:0] exp);
        io_peek_sel_in = a;
        repeat (2) @(negedge clk_in);
        chk8("io register", exp, io_peek_data_out);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [8:0] exp_shift(input op_t op,
                                             input logic [7:0] v,
                                             input logic ci);
        case (op)
            shift_left_logical_op:  return {v[7], v[6:0], 1'b0};
            shift_right_logical_op: return {v[0], 1'b0, v[7:1]};
            shift_right_arith_op:   return {v[0], v[7], v[7:1]};
            rotate_left_carry_op:   return {v[7], v[6:0], ci};
            rotate_right_carry_op:  return {v[0], ci, v[7:1]};
            default:                return {ci, v[3:0], v[7:4]};
        endcase
    endfunction

    // A hang counts as a failure; the whole run needs well under 2000.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk_in);
        resetn_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            st[i] = 1'b1;
            exec(indexed_flag_on_op, 5'h00, 5'h00, 3'(i), 8'h00, 1);
        end
        for (int i = 0; i < 8; i++) begin
            st[i] = 1'b0;
            exec(indexed_flag_off_op, 5'h00, 5'h00, 3'(i), 8'h00, 1);
        end
        st[7] = 1'b1;
        exec(global_irq_on_op, 5'h00, 5'h00, 3'h0, 8'h00, 1);
        st[7] = 1'b0;
        exec(global_irq_off_op, 5'h00, 5'h00, 3'h0, 8'h00, 1);
        exec(immediate_load_op, 5'h12, 5'h00, 3'h0, 8'h12, 1);
        exec(immediate_load_op, 5'h13, 5'h00, 3'h0, 8'h34, 1);
        exec(reg_pair_copy_op, 5'h14, 5'h12, 3'h0, 8'h00, 1);
        peek(5'h14, 8'h12);
        peek(5'h15, 8'h34);
        exec(reg_copy_op, 5'h10, 5'h13, 3'h0, 8'h00, 1);
        peek(5'h10, 8'h34);
        exec(immediate_load_op, 5'h16, 5'h00, 3'h0, 8'h08, 1);
        st[6] = 1'b1;
        exec(bit_to_transfer_flag_op, 5'h00, 5'h16, 3'h3, 8'h00, 1);
        exec(transfer_flag_to_bit_op, 5'h17, 5'h00, 3'h5, 8'h00, 1);
        peek(5'h17, 8'h20);
        foreach (sh_ops[i]) begin
            foreach (vals[j]) begin
                st[0] = j[0];
                exec(op_t'(j[0] ? indexed_flag_on_op : indexed_flag_off_op),
                     5'h00, 5'h00, 3'h0, 8'h00, 1);
                exec(immediate_load_op, 5'h10, 5'h00, 3'h0, vals[j], 1);
                e = exp_shift(sh_ops[i], vals[j], st[0]);
                if (sh_ops[i] != nibble_swap_op) begin
                    st[0] = e[8];
                    st[1] = (e[7:0] == 8'h00);
                    st[2] = e[7];
                    st[3] = e[7] ^ e[8];
                end
                exec(sh_ops[i], 5'h10, 5'h10, 3'h0, 8'h00, 1);
                peek(5'h10, e[7:0]);
            end
        end
        io_addr_in = 5'h05;
        exec(io_bit_set_op, 5'h00, 5'h00, 3'h2, 8'h00, 2);
        iopeek(5'h05, 8'h04);
        exec(io_bit_set_op, 5'h00, 5'h00, 3'h7, 8'h00, 2);
        exec(io_bit_clear_op, 5'h00, 5'h00, 3'h2, 8'h00, 2);
        iopeek(5'h05, 8'h80);
        exec(immediate_load_op, 5'h1A, 5'h00, 3'h0, 8'hFF, 1);
        exec(immediate_load_op, 5'h1B, 5'h00, 3'h0, 8'h00, 1);
        mem_data_in = 8'hA5;
        ptr_mode_in = ptr_post_inc;
        exec(pointer_load_op, 5'h01, 5'h00, 3'h0, 8'h00, 2);
        chk16("load address", 16'h00FF, mem_addr_out);
        peek(5'h01, 8'hA5);
        peek(5'h1A, 8'h00);
        peek(5'h1B, 8'h01);
        exec(immediate_load_op, 5'h1C, 5'h00, 3'h0, 8'h00, 1);
        exec(immediate_load_op, 5'h1D, 5'h00, 3'h0, 8'h01, 1);
        mem_data_in = 8'h5A;
        ptr_sel_in = ptr_y;
        ptr_mode_in = ptr_pre_dec;
        exec(pointer_load_op, 5'h02, 5'h00, 3'h0, 8'h00, 2);
        chk16("load address", 16'h00FF, mem_addr_out);
        peek(5'h02, 8'h5A);
        peek(5'h1C, 8'hFF);
        peek(5'h1D, 8'h00);
        mem_data_in = 8'h3C;
        ptr_mode_in = ptr_plain;
        exec(pointer_load_op, 5'h03, 5'h00, 3'h0, 8'h00, 2);
        chk16("load address", 16'h00FF, mem_addr_out);
        peek(5'h03, 8'h3C);
        peek(5'h1C, 8'hFF);
        give_verdict();
    end
endmodule
